// ---- rtl/mdio_vendor_defs.svh ----
/*
  Constants of the vendor management register bank: register offsets,
  field positions, reset values, frame lengths and mode codes.
  Assumes inclusion by bare name from the design files of the bank.
*/
`ifndef MDIO_VENDOR_DEFS_SVH
`define MDIO_VENDOR_DEFS_SVH

// ****************************************
// Addressing
// ****************************************
`define VENDOR_DEVAD 5'h1E
`define GC_ADDR 16'h0000
`define STAT_ADDR 16'h0010
`define ERRCNT_ADDR 16'h0011
`define TEST_ADDR 16'h0012

// ****************************************
// Global control layout
// ****************************************
`define GC_RESET 16'h0610
`define GC_STORE_MASK 16'h77BF
`define GC_SOFT_RST 15
`define GC_SEL_HI 14
`define GC_SEL_LO 12
`define GC_PIN_DIS 5
`define GC_OVL_HI 4
`define GC_OVL_LO 0
`define PIN_STOPWATCH 3'h0
`define PIN_TX_SWITCH 3'h2
`define PIN_RX_SWITCH 3'h3

// ****************************************
// Frame timing, counted in management clock bits
// ****************************************
`define PREAMBLE_LEN 6'h20
`define HDR_LAST 6'h0D
`define DATA_LAST 6'h0F

// ****************************************
// Operating modes
// ****************************************
`define MODE_KR 2'h0
`define MODE_KX 2'h1
`define MODE_GP 2'h2

`endif

// ---- rtl/mdio_vendor_pkg.sv ----
/*
  Types shared by the vendor register bank: the frame engine states.
  Assumes nothing of its surroundings.
*/
package mdio_vendor_pkg;
  // Frame engine position within a management frame
  typedef enum logic [1:0] {
    st_pre,
    st_hdr,
    st_ta,
    st_data
  } frame_state_t;
endpackage

// ---- rtl/mdio_vendor_register_bank.sv ----
/*
  Vendor register bank behind a management serial pin pair, accepting
  long-form and short-form frames, with global control, status and
  counter registers. Assumes the management clock is far slower than
  the core clock and that datapath signals share the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mdio_vendor_defs.svh"
module mdio_vendor_register_bank
  import mdio_vendor_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic [4:0] phy_addr_i,
  input wire logic port_addr_bit0_pin_i,
  input wire logic [1:0] op_mode_i,
  input wire logic lh_cond_i,
  input wire logic ll_cond_i,
  input wire logic ro_stat_i,
  input wire logic err_pulse_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  output logic dp_reset_o,
  output logic [2:0] port_pin_function_select_o,
  output logic port_pin_function_disable_o,
  output logic [4:0] pattern_check_status_select_o,
  output logic stopwatch_o,
  output logic tx_data_switch_o,
  output logic rx_data_switch_o,
  output logic test_pulse_o
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] mdc_s_q; // Two sync stages plus edge history
  logic [1:0] mdio_s_q; // Same depth keeps data aligned to clock
  logic [4:0] pa_s1_q, pa_s2_q; // Port address strap
  logic [1:0] pin_s_q; // Port address bit 0 pin

  // Only the second stage is read beyond the first, plus the third MDC stage for edge detection
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mdc_s_q <= 3'h0;
      mdio_s_q <= 2'h0;
      pa_s1_q <= 5'h00;
      pa_s2_q <= 5'h00;
      pin_s_q <= 2'h0;
    end else begin
      mdc_s_q <= {mdc_s_q[1:0], mdc_i};
      mdio_s_q <= {mdio_s_q[0], mdio_i};
      pa_s1_q <= phy_addr_i;
      pa_s2_q <= pa_s1_q;
      pin_s_q <= {pin_s_q[0], port_addr_bit0_pin_i};
    end
  end

  // ****************************************
  // Frame decode
  // ****************************************
  frame_state_t state_q; // Frame position
  logic [5:0] cnt_q; // Bit counter
  logic [13:0] hdr_q; // Start, op, port, device bits
  logic [15:0] shift_q; // Read data out, write data in
  logic [15:0] addr_q; // Long-form address pointer
  logic [15:0] acc_addr_q; // Address of the frame in flight
  logic c22_q, sel_q, rd_act_q;
  logic [1:0] op_q;
  logic mdc_rise_w, bit_w, c22_w, c45_w, sel_w, is_read_w;
  logic hdr_done_w, data_done_w, rd_stb_w, wr_stb_w;
  logic [13:0] hdr_w;
  logic [15:0] hdr_addr_w, wr_data_w, rd_data_w;

  assign mdc_rise_w = mdc_s_q[1] & ~mdc_s_q[2];
  assign bit_w = mdio_s_q[1];
  assign hdr_w = {hdr_q[12:0], bit_w};
  assign c22_w = hdr_w[13:12] == 2'h1;
  assign c45_w = hdr_w[13:12] == 2'h0;
  // Short frames need no device code; long ones need the vendor's
  assign sel_w = (hdr_w[9:5] == pa_s2_q)
    && (c22_w || (c45_w && hdr_w[4:0] == `VENDOR_DEVAD));
  assign is_read_w = c22_w ? (hdr_w[11:10] == 2'h2) : hdr_w[11];
  // Short frames reach the register sharing the low five bits
  assign hdr_addr_w = c22_w ? {11'h000, hdr_w[4:0]} : addr_q;
  assign hdr_done_w = mdc_rise_w && state_q == st_hdr
    && cnt_q == `HDR_LAST;
  assign data_done_w = mdc_rise_w && state_q == st_data
    && cnt_q == `DATA_LAST;
  assign rd_stb_w = hdr_done_w && sel_w && is_read_w;
  assign wr_stb_w = data_done_w && sel_q && !rd_act_q && op_q == 2'h1;
  assign wr_data_w = {shift_q[14:0], bit_w};

  // One step per management clock rise
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= st_pre;
      cnt_q <= 6'h00;
      hdr_q <= 14'h0000;
      shift_q <= 16'h0000;
      addr_q <= 16'h0000;
      acc_addr_q <= 16'h0000;
      c22_q <= 1'b0;
      op_q <= 2'h0;
      sel_q <= 1'b0;
      rd_act_q <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (mdc_rise_w) begin
      case (state_q)
        st_pre: begin
          // Count ones, the first zero after a full run starts a frame
          if (bit_w) begin
            cnt_q <= (cnt_q == `PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
          end else if (cnt_q == `PREAMBLE_LEN) begin
            state_q <= st_hdr;
            hdr_q <= 14'h0000;
            cnt_q <= 6'h01;
          end else begin
            cnt_q <= 6'h00;
          end
        end
        st_hdr: begin
          hdr_q <= hdr_w;
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == `HDR_LAST) begin
            state_q <= st_ta;
            cnt_q <= 6'h00;
            c22_q <= c22_w;
            op_q <= hdr_w[11:10];
            sel_q <= sel_w;
            rd_act_q <= rd_stb_w;
            acc_addr_q <= hdr_addr_w;
            shift_q <= rd_data_w; // Snapshot taken with read effects
          end
        end
        st_ta: begin
          if (cnt_q == 6'h00) begin
            // First turnaround bit floats, second is driven low
            cnt_q <= 6'h01;
            mdio_oe_o <= rd_act_q;
            mdio_o <= 1'b0;
          end else begin
            state_q <= st_data;
            cnt_q <= 6'h00;
            mdio_o <= shift_q[15];
            shift_q <= {shift_q[14:0], 1'b0};
          end
        end
        st_data: begin
          shift_q <= wr_data_w;
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == `DATA_LAST) begin
            state_q <= st_pre;
            cnt_q <= 6'h00;
            mdio_oe_o <= 1'b0;
            mdio_o <= 1'b0;
            if (sel_q && !c22_q && op_q == 2'h0) begin
              addr_q <= wr_data_w; // Address frame
            end else if (sel_q && !c22_q && op_q == 2'h2) begin
              addr_q <= addr_q + 16'h0001; // Read with post-increment
            end
          end else begin
            mdio_o <= shift_q[15];
          end
        end
        default: begin
          state_q <= st_pre;
        end
      endcase
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [15:0] gc_q; // Global control storage
  logic [15:0] errcnt_q; // Error counter
  logic kr_w, kx_w, gp_w, lh_bit_w, ll_bit_w, inc_w;
  logic wr_gc_w, rd_stat_w, rd_cnt_w, lh_act_w, ll_act_w;
  logic [15:0] gc_next_w;

  assign kr_w = op_mode_i == `MODE_KR;
  assign kx_w = op_mode_i == `MODE_KX;
  assign gp_w = op_mode_i == `MODE_GP;
  assign lh_act_w = lh_cond_i & (kr_w | kx_w);
  assign ll_act_w = ll_cond_i & (kr_w | gp_w);
  assign inc_w = err_pulse_i & kr_w;
  assign wr_gc_w = wr_stb_w && acc_addr_q == `GC_ADDR;
  assign rd_stat_w = rd_stb_w && hdr_addr_w == `STAT_ADDR;
  assign rd_cnt_w = rd_stb_w && hdr_addr_w == `ERRCNT_ADDR;
  // Reserved and self-clearing bits are never stored
  assign gc_next_w = wr_data_w & `GC_STORE_MASK;

  // Read selection; unmapped addresses read zero
  always_comb begin
    if (hdr_addr_w == `GC_ADDR) begin
      rd_data_w = gc_q;
    end else if (hdr_addr_w == `STAT_ADDR) begin
      rd_data_w = {13'h0000, ro_stat_i, ll_bit_w, lh_bit_w};
    end else if (hdr_addr_w == `ERRCNT_ADDR) begin
      rd_data_w = errcnt_q;
    end else begin
      rd_data_w = 16'h0000;
    end
  end

  status_latch_cell #(.ACTIVE_LOW(1'b0)) u_lh (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .soft_clr_i(dp_reset_o),
    .valid_i(kr_w | kx_w),
    .cond_i(lh_cond_i),
    .rd_clr_i(rd_stat_w),
    .value_o(lh_bit_w)
  );

  status_latch_cell #(.ACTIVE_LOW(1'b1)) u_ll (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .soft_clr_i(dp_reset_o),
    .valid_i(kr_w | gp_w),
    .cond_i(ll_cond_i),
    .rd_clr_i(rd_stat_w),
    .value_o(ll_bit_w)
  );

  // Control, soft reset and counter; soft reset lasts one cycle
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gc_q <= `GC_RESET;
      dp_reset_o <= 1'b0;
      errcnt_q <= 16'h0000;
      test_pulse_o <= 1'b0;
    end else begin
      dp_reset_o <= wr_gc_w && wr_data_w[`GC_SOFT_RST];
      test_pulse_o <= wr_stb_w && acc_addr_q == `TEST_ADDR
        && wr_data_w[0];
      if (dp_reset_o) begin
        gc_q <= `GC_RESET;
        errcnt_q <= 16'h0000;
      end else begin
        if (wr_gc_w) begin
          gc_q <= gc_next_w;
        end
        // A pulse landing on the clearing read is kept
        if (rd_cnt_w) begin
          errcnt_q <= {15'h0000, inc_w};
        end else if (inc_w && errcnt_q != 16'hFFFF) begin
          errcnt_q <= errcnt_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // Field fan-out
  // ****************************************
  logic [2:0] psel_w;
  logic pin_en_w;
  assign psel_w = gc_q[`GC_SEL_HI:`GC_SEL_LO];
  assign pin_en_w = !gc_q[`GC_PIN_DIS];

  // Pin steers one function only while the disable bit is clear
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_pin_function_select_o <= 3'h0;
      port_pin_function_disable_o <= 1'b0;
      pattern_check_status_select_o <= 5'h10;
      stopwatch_o <= 1'b0;
      tx_data_switch_o <= 1'b0;
      rx_data_switch_o <= 1'b0;
    end else begin
      port_pin_function_select_o <= psel_w;
      port_pin_function_disable_o <= gc_q[`GC_PIN_DIS];
      pattern_check_status_select_o <= gc_q[`GC_OVL_HI:`GC_OVL_LO];
      stopwatch_o <= pin_en_w && psel_w == `PIN_STOPWATCH
        && pin_s_q[1];
      tx_data_switch_o <= pin_en_w && psel_w == `PIN_TX_SWITCH
        && pin_s_q[1];
      rx_data_switch_o <= pin_en_w && psel_w == `PIN_RX_SWITCH
        && pin_s_q[1];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence sc_write_s;
    wr_stb_w && acc_addr_q == `TEST_ADDR && wr_data_w[0];
  endsequence
  sequence sr_write_s;
    wr_gc_w && wr_data_w[`GC_SOFT_RST];
  endsequence

  a_rw_store: assert property (
    wr_gc_w && !wr_data_w[`GC_SOFT_RST]
      |=> gc_q == ($past(wr_data_w) & `GC_STORE_MASK))
    else $error("global control did not keep written value");
  a_sc_pulse: assert property (
    sc_write_s |=> test_pulse_o ##1 !test_pulse_o)
    else $error("self-clearing bit pulse not one cycle");
  a_ro_live: assert property (
    rd_stat_w |=> shift_q[2] == $past(ro_stat_i))
    else $error("read-only bit not live");
  a_lh_clear: assert property (
    rd_stat_w && !lh_act_w ##1 !lh_act_w |-> !lh_bit_w)
    else $error("latched-high bit not cleared by read");
  a_ll_set: assert property (
    rd_stat_w && !ll_act_w ##1 !ll_act_w |-> ll_bit_w)
    else $error("latched-low bit not set by read");
  a_cor_hold: assert property (
    errcnt_q == 16'hFFFF && !rd_cnt_w && !dp_reset_o
      |=> errcnt_q == 16'hFFFF)
    else $error("counter wrapped or left max");
  a_mode_gate: assert property (
    !kr_w && !rd_cnt_w && !dp_reset_o |=> $stable(errcnt_q))
    else $error("counter moved outside its mode");
  a_devad_select: assert property (
    hdr_done_w && !c22_w && hdr_w[4:0] != `VENDOR_DEVAD |=> !sel_q)
    else $error("long frame for other device selected");
  a_short_addr: assert property (
    hdr_done_w && c22_w
      |=> acc_addr_q == {11'h000, $past(hdr_w[4:0])})
    else $error("short frame address not mapped");
  a_soft_reset: assert property (
    sr_write_s |=> dp_reset_o ##1 (!dp_reset_o && gc_q == `GC_RESET))
    else $error("soft reset not one cycle to default");
  a_pin_route: assert property (
    pin_en_w && psel_w == `PIN_TX_SWITCH
      |=> tx_data_switch_o == $past(pin_s_q[1]))
    else $error("port pin not routed to selected use");
  a_rsv_zero: assert property (
    rd_stb_w && hdr_addr_w == `GC_ADDR
      |=> !shift_q[15] && !shift_q[11] && !shift_q[6])
    else $error("reserved or self-clearing bit read nonzero");
endmodule // mdio_vendor_register_bank
`default_nettype wire

// ---- rtl/status_latch_cell.sv ----
/*
  One latched status bit: remembers an event until the bank reads it.
  Assumes the condition and the read strobe are on the bank's clock.
*/
`timescale 1ns/1ns
`default_nettype none
module status_latch_cell #(
  parameter bit ACTIVE_LOW = 1'b0
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic soft_clr_i,
  input wire logic valid_i,
  input wire logic cond_i,
  input wire logic rd_clr_i,
  output logic value_o
);
  // ****************************************
  // Event memory
  // ****************************************
  logic ev_q; // Event seen since last read
  logic act_w; // Condition counts only in a valid mode
  logic seen_w; // Now or since last read

  assign act_w = valid_i & cond_i;
  assign seen_w = ev_q | act_w;
  // Latched-low shows the inverse sense
  assign value_o = ACTIVE_LOW ? ~seen_w : seen_w;

  // Read clears, but a live condition re-arms in the same cycle
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_q <= 1'b0;
    end else if (soft_clr_i) begin
      ev_q <= 1'b0;
    end else if (rd_clr_i) begin
      ev_q <= act_w;
    end else begin
      ev_q <= seen_w;
    end
  end
endmodule // status_latch_cell
`default_nettype wire

// ---- testbench/mdio_station_model.sv ----
/*
  Station controller model: sends management frames on MDC/MDIO.
  Assumes the bench resolves the shared data line with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none
module mdio_station_model #(
  parameter int HALF = 5
) (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic mdc_o,
  output logic drv_o,
  output logic en_o,
  output logic done_o,
  output logic [15:0] rdata_o
);
  // Clock stands low and the line is released between frames
  initial begin
    mdc_o = 1'b0;
    drv_o = 1'b1;
    en_o = 1'b0;
    done_o = 1'b0;
    rdata_o = 16'h0000;
  end

  // One bit: data set while MDC is low, line sampled at the rise
  task automatic bit_cycle(input logic v, input logic en, output logic s);
    @(posedge mclk_i);
    #1;
    mdc_o = 1'b0;
    en_o = en;
    drv_o = v;
    repeat (HALF - 1) @(posedge mclk_i);
    #1;
    s = line_i;
    mdc_o = 1'b1;
    repeat (HALF - 1) @(posedge mclk_i);
  endtask

  // Whole frame; read frames release the line from the turnaround on
  task automatic xfer(input logic [1:0] st, input logic [1:0] op,
                      input logic [4:0] phy, input logic [4:0] dev,
                      input logic [15:0] wd);
    logic [31:0] hdr;
    logic rd;
    logic s;
    int i;
    rd = (st == 2'b01) ? (op == 2'b10) : op[1];
    hdr = {st, op, phy, dev, 2'b10, wd};
    for (i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
    for (i = 31; i >= 0; i--) begin
      bit_cycle(hdr[i], !(rd && i < 18), s);
      if (i < 16) rdata_o[i] = s;
    end
    @(posedge mclk_i);
    #1;
    mdc_o = 1'b0;
    en_o = 1'b0;
    done_o = rd;
    @(posedge mclk_i);
    #1;
    done_o = 1'b0;
  endtask
endmodule // mdio_station_model
`default_nettype wire

// ---- testbench/tb_mdio_vendor_register_bank.sv ----
/*
  Bench for the vendor register bank: read data queued by the driver,
  compared by a monitor. Assumes the station model in its own file.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mdio_vendor_defs.svh"
module tb_mdio_vendor_register_bank
  import mdio_vendor_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [4:0] PHY = 5'h05;
  logic mclk, nrst, mdc, line, drv, en, done, pin, lh, ll, ro, err;
  logic mdio_o, mdio_oe_o, dp_reset_o, pdis, stopw, txs, rxs, tpulse;
  logic [1:0] mode;
  logic [2:0] psel;
  logic [4:0] pat;
  logic [15:0] rdata, wd;
  logic [15:0] exp_q[$];
  logic [3:0] cfg[4] = '{4'b0000, 4'b0100, 4'b0110, 4'b0001};
  logic [2:0] pexp[4] = '{3'h4, 3'h2, 3'h1, 3'h0};
  int mismatches, num_checks, n_test, n_rst, seed, i, n;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Pull-up wins when neither end drives
  assign line = mdio_oe_o ? mdio_o : (en ? drv : 1'b1);

  mdio_vendor_register_bank u_mdio_vendor_register_bank (
    .mclk_i(mclk), .nrst_i(nrst), .mdc_i(mdc), .mdio_i(line),
    .phy_addr_i(PHY), .port_addr_bit0_pin_i(pin), .op_mode_i(mode),
    .lh_cond_i(lh), .ll_cond_i(ll), .ro_stat_i(ro), .err_pulse_i(err),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .dp_reset_o(dp_reset_o),
    .port_pin_function_select_o(psel),
    .port_pin_function_disable_o(pdis),
    .pattern_check_status_select_o(pat), .stopwatch_o(stopw),
    .tx_data_switch_o(txs), .rx_data_switch_o(rxs),
    .test_pulse_o(tpulse));

  mdio_station_model u_mdio_station_model (
    .mclk_i(mclk), .line_i(line), .mdc_o(mdc), .drv_o(drv), .en_o(en),
    .done_o(done), .rdata_o(rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    num_checks++;
    if (seen !== expv) begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, seen, expv);
    end
  endtask

  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Monitor: pulse counts and the oldest queued read expectation
  always @(posedge mclk) begin
    if (tpulse === 1'b1) n_test++;
    if (dp_reset_o === 1'b1) n_rst++;
    if (done === 1'b1) begin
      check(rdata, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    end
  end

  task automatic sw(input logic [4:0] a, input logic [15:0] d);
    u_mdio_station_model.xfer(2'b01, 2'b01, PHY, a, d);
  endtask

  task automatic sr(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_mdio_station_model.xfer(2'b01, 2'b10, PHY, a, 16'h0000);
  endtask

  // Long form: address frame, then write or read
  task automatic lf(input logic [4:0] dv, input logic [15:0] d,
                    input logic rd);
    u_mdio_station_model.xfer(2'b00, 2'b00, PHY, dv, `GC_ADDR);
    if (rd) exp_q.push_back(d);
    u_mdio_station_model.xfer(2'b00, rd ? 2'b11 : 2'b01, PHY, dv, d);
  endtask

  // One-cycle events on {latched-high, latched-low, error}
  task automatic ev(input logic [2:0] k);
    @(posedge mclk);
    #1;
    {lh, ll, err} = k;
    @(posedge mclk);
    #1;
    {lh, ll, err} = 3'b000;
  endtask

  function automatic logic [15:0] stat_word(input logic l, input logic h);
    return {13'h0000, ro, l, h};
  endfunction

  // Watchdog: a little over the expected ~90k cycles, kept under 100k
  initial begin
    repeat (98000) @(posedge mclk);
    mismatches++;
    finish_test();
  end

  initial begin
    seed = 32'hd7fa;
    {mismatches, num_checks, n_test, n_rst} = '0;
    {nrst, pin, lh, ll, ro, err} = '0;
    mode = 2'h0;
    repeat (3) @(posedge mclk);
    #1 nrst = 1'b1;
    check({11'h000, pat}, 16'h0010);
    sr(5'h00, `GC_RESET);
    // Random image, soft reset bit kept clear
    wd = 16'($random(seed)) & 16'h7FFF;
    sw(5'h00, wd);
    sr(5'h00, wd & `GC_STORE_MASK);
    check(16'({psel, pdis, pat}), 16'({wd[14:12], wd[5], wd[4:0]}));
    // Wrong device code: write dropped, read left to the pull-up
    lf(5'h1D, 16'h0000, 1'b0);
    lf(5'h1D, 16'hFFFF, 1'b1);
    lf(`VENDOR_DEVAD, wd & `GC_STORE_MASK, 1'b1);
    // Read with post-increment: control word, then the unmapped next one
    exp_q.push_back(wd & `GC_STORE_MASK);
    exp_q.push_back(16'h0000);
    u_mdio_station_model.xfer(2'b00, 2'b10, PHY, `VENDOR_DEVAD, wd);
    u_mdio_station_model.xfer(2'b00, 2'b11, PHY, `VENDOR_DEVAD, wd);
    exp_q.push_back(16'hFFFF);
    u_mdio_station_model.xfer(2'b01, 2'b10, PHY ^ 5'h01, 5'h00, 16'h0000);
    // Port pin routing per select and disable
    pin = 1'b1;
    for (i = 0; i < 4; i++) begin
      sw(5'h00, {1'b0, cfg[i][3:1], 6'h00, cfg[i][0], 5'h10});
      repeat (4) @(posedge mclk);
      check({13'h0000, stopw, txs, rxs}, {13'h0000, pexp[i]});
    end
    sw(5'h12, 16'h0000);
    sw(5'h12, 16'h0001);
    sr(5'h12, 16'h0000);
    check(16'(n_test), 16'h0001);
    // Every mode: events, read, then reread
    for (i = 0; i < 4; i++) begin
      mode = 2'(i);
      ro = 1'($random(seed));
      ev(3'b111);
      sr(5'h10, stat_word(i[0], i < 2));
      sr(5'h10, stat_word(1'b1, 1'b0));
      sr(5'h11, 16'(i == 0));
    end
    mode = 2'h0;
    lh = 1'b1;
    sr(5'h10, stat_word(1'b1, 1'b1));
    sr(5'h10, stat_word(1'b1, 1'b1));
    lh = 1'b0;
    sw(5'h10, 16'hFFFF);
    sw(5'h11, 16'h1234);
    sr(5'h10, stat_word(1'b1, 1'b1));
    sr(5'h11, 16'h0000);
    n = 1 + ($unsigned($random(seed)) % 20);
    for (i = 0; i < n; i++) ev(3'b001);
    sr(5'h11, 16'(n));
    // Saturation: error held for more than a full count
    @(posedge mclk);
    #1 err = 1'b1;
    repeat (65540) @(posedge mclk);
    #1 err = 1'b0;
    sr(5'h11, 16'hFFFF);
    sr(5'h11, 16'h0000);
    sw(5'h00, 16'h8025);
    sr(5'h00, `GC_RESET);
    check(16'(n_rst), 16'h0001);
    finish_test();
  end
endmodule // tb_mdio_vendor_register_bank
`default_nettype wire
